// *** logic/amp_supervisor.sv ***
// Protection, clock supervision, sample capture and output mode control.
// Assumes pin inputs are asynchronous; the register port is on ref_clk.
`timescale 1ns/1ns
`include "amp_supervisor_map.svh"
module amp_supervisor
  import amp_supervisor_pkg::*;
#(
  parameter int unsigned FRAME_TIMEOUT = `FRAME_TIMEOUT_CYC,
  parameter int unsigned RAMP_STEP     = `RAMP_STEP_CYC
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Audio pins and analog fault sensors
  input  wire audio_pins_s  audio_in,
  input  wire fault_sense_s sense_in,
  // Address strap and fault pin
  input  wire logic         addr_fault_pin_i,
  output logic              addr_fault_pin_o,
  output logic              addr_fault_pin_oe,
  output logic [6:0]        bus_addr,
  // Register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_wr_en,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_rd_en,
  output logic [31:0]       reg_rdata,
  // Static configuration
  input  wire logic [2:0]   dc_block_en,
  input  wire logic [2:0]   deemph_en,
  input  wire logic         mod_limit_high,
  // Power stage and clock control
  output logic [3:0]        stage_hiz,
  output logic              operational,
  output logic              core_clk_from_osc,
  output logic              pll_reduced,
  output logic [1:0]        bclk_ratio,
  output logic              audio_muted,
  output logic              midz_ramp_en,
  output logic              mode_2p1,
  output logic              parallel_bridge_mode,
  output logic [7:0]        pwm_shutdown,
  output logic [31:0]       output_mux,
  // PCM stream to the modulators
  output logic              pcm_valid,
  output pcm_word_s         pcm_word,
  input  wire logic         pcm_ready
);
  typedef struct packed {
    pins_s       sync0;
    pins_s       sync1;
    logic        por_ok;
    logic        strap_done;
    logic        strap;
    oc_state_e   oc_state;
    logic [7:0]  oc_cnt;
    logic [15:0] unit_cnt;
    logic [7:0]  retry_cnt;
    logic        thermal_sd;
    logic [3:0]  hiz;
    logic        fault_low;
    logic [3:0]  err;
    logic [7:0]  mode;
    logic [7:0]  vol;
    logic [7:0]  shut;
    logic [7:0]  retry;
    logic [31:0] pol;
    logic [31:0] mux;
    logic [31:0] rdata;
    clk_state_e  clk_state;
    logic [2:0]  atten;
    logic [15:0] step_cnt;
    logic        use_osc;
    logic        pll_red;
    logic        muted;
    logic [1:0]  ratio;
    logic        bclk_prev;
    logic        lr_prev;
    logic [23:0] shift;
    logic [5:0]  bit_cnt;
    logic [23:0] left;
    logic        st_valid;
    pcm_word_s   st;
    logic        sub_pend;
    logic [23:0] sub_data;
  } top_s;
  top_s s_q, s_d;

  logic       chk_bad;
  logic       chk_mbad;
  logic       chk_stable;
  logic [1:0] chk_ratio;
  logic       buf_ready;

  ////////////////////////////////////////////////////////////////////////
  // Sample conditioning: invert, limit, attenuate, mute
  function automatic logic [23:0] condition(input logic [23:0] x, input logic [1:0] ch,
                                            input top_s s, input logic hi_lim);
    logic [23:0] lim;
    logic [23:0] v;
    lim = hi_lim ? `MOD_MAX_992 : `MOD_MAX_938;
    v   = s.pol[`POL_LSB + ch] ? 24'(-x) : x;
    if (!v[23] && v > lim) begin
      v = lim;
    end else if (v[23] && v < 24'(-lim)) begin
      v = 24'(-lim);
    end
    v = 24'($signed(v) >>> s.atten);
    return s.muted ? 24'h000000 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        oc_any;
    logic        uv_any;
    logic        bclk_rise;
    logic        lr_edge;
    logic [23:0] word;
    logic        new_v;
    pcm_word_s   new_w;
    oc_any    = 1'b0;
    uv_any    = 1'b0;
    bclk_rise = 1'b0;
    lr_edge   = 1'b0;
    word      = 24'h000000;
    new_v     = 1'b0;
    new_w     = '0;
    s_d       = s_q;
    s_d.sync0 = {audio_in, sense_in, addr_fault_pin_i};
    s_d.sync1 = s_q.sync0;

    // Power-on gating and address strap
    s_d.por_ok = s_q.sync1.sense.analog_por_ok & s_q.sync1.sense.stage_por_ok;
    if (s_q.por_ok && !s_q.strap_done) begin
      s_d.strap      = s_q.sync1.addr_pin;
      s_d.strap_done = 1'b1;
    end

    // Overcurrent: any switch counts, persistence then latched retry
    oc_any = |s_q.sync1.sense.oc_detect;
    unique case (s_q.oc_state)
      OC_RUN: begin
        s_d.oc_cnt = oc_any ? s_q.oc_cnt + 8'h01 : 8'h00;
        if (oc_any && s_q.oc_cnt == 8'(`OC_PERSIST_CYC - 1)) begin
          s_d.oc_state  = OC_HOLD;
          s_d.unit_cnt  = 16'h0000;
          s_d.retry_cnt = 8'h00;
        end
      end
      OC_HOLD: begin
        s_d.oc_cnt = 8'h00;
        if (s_q.retry_cnt == s_q.retry) begin
          s_d.oc_state = OC_RUN;
        end else if (s_q.unit_cnt == 16'(`RETRY_UNIT_CYC - 1)) begin
          s_d.unit_cnt  = 16'h0000;
          s_d.retry_cnt = s_q.retry_cnt + 8'h01;
        end else begin
          s_d.unit_cnt = s_q.unit_cnt + 16'h0001;
        end
      end
    endcase

    // Thermal shutdown with hysteresis from the two comparators
    if (s_q.sync1.sense.overtemp_trip) begin
      s_d.thermal_sd = 1'b1;
    end else if (s_q.sync1.sense.overtemp_release) begin
      s_d.thermal_sd = 1'b0;
    end

    uv_any = s_q.sync1.sense.analog_uv | (|s_q.sync1.sense.stage_uv);
    // All four half-bridges always go together
    s_d.hiz = {4{~s_q.por_ok | (s_q.oc_state == OC_HOLD) | s_q.thermal_sd | uv_any}};

    // Register port; a write to status clears bits written as zero
    s_d.rdata = s_q.rdata;
    if (reg_wr_en) begin
      unique case (reg_addr)
        `OFS_ERROR_STATUS:  s_d.err   = s_q.err & reg_wdata[3:0];
        `OFS_SYSTEM_MODE:   s_d.mode  = reg_wdata[7:0];
        `OFS_VOLUME_UNMUTE: s_d.vol   = reg_wdata[7:0];
        `OFS_PWM_SHUTDOWN:  s_d.shut  = reg_wdata[7:0];
        `OFS_RETRY_DELAY:   s_d.retry = reg_wdata[7:0];
        `OFS_POLARITY:      s_d.pol   = reg_wdata;
        `OFS_OUTPUT_MUX:    s_d.mux   = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        `OFS_ERROR_STATUS:  s_d.rdata = {28'h0000000, s_q.err};
        `OFS_SYSTEM_MODE:   s_d.rdata = {24'h000000, s_q.mode};
        `OFS_VOLUME_UNMUTE: s_d.rdata = {24'h000000, s_q.vol};
        `OFS_PWM_SHUTDOWN:  s_d.rdata = {24'h000000, s_q.shut};
        `OFS_RETRY_DELAY:   s_d.rdata = {24'h000000, s_q.retry};
        `OFS_POLARITY:      s_d.rdata = s_q.pol;
        `OFS_OUTPUT_MUX:    s_d.rdata = s_q.mux;
        default:            s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Clock supervision and recovery
    s_d.use_osc = chk_mbad;
    unique case (s_q.clk_state)
      CLK_OK: begin
        if (chk_bad || (s_q.ratio != chk_ratio)) begin
          s_d.clk_state = CLK_MUTE;
          s_d.muted     = 1'b1;
          s_d.pll_red   = 1'b1;
        end
      end
      CLK_MUTE: begin
        if (chk_stable) begin
          s_d.ratio   = chk_ratio;
          s_d.muted   = 1'b0;
          s_d.pll_red = 1'b0;
          if (s_q.vol[`BIT_SOFT_UNMUTE]) begin
            s_d.clk_state = CLK_RAMP;
            s_d.atten     = 3'd7;
            s_d.step_cnt  = 16'h0000;
          end else begin
            s_d.clk_state = CLK_OK;
            s_d.atten     = 3'd0;
          end
        end
      end
      CLK_RAMP: begin
        if (chk_bad) begin
          s_d.clk_state = CLK_MUTE;
          s_d.muted     = 1'b1;
          s_d.pll_red   = 1'b1;
        end else if (s_q.step_cnt == 16'(RAMP_STEP - 1)) begin
          s_d.step_cnt = 16'h0000;
          s_d.atten    = s_q.atten - 3'd1;
          if (s_q.atten == 3'd1) begin
            s_d.clk_state = CLK_OK;
          end
        end else begin
          s_d.step_cnt = s_q.step_cnt + 16'h0001;
        end
      end
      default: begin
        s_d.clk_state = CLK_MUTE;
        s_d.muted     = 1'b1;
      end
    endcase

    // Sticky status; a live event wins over a clear in the same cycle
    s_d.err[`ERR_OC]  = s_d.err[`ERR_OC] | (s_q.oc_state == OC_HOLD);
    s_d.err[`ERR_OT]  = s_d.err[`ERR_OT] | s_q.thermal_sd;
    s_d.err[`ERR_UV]  = s_d.err[`ERR_UV] | uv_any;
    s_d.err[`ERR_CLK] = s_d.err[`ERR_CLK] | (s_q.clk_state != CLK_OK);
    s_d.fault_low = s_q.strap_done & (|s_d.err[2:0]);

    // Serial capture, first 24 bits after each frame clock edge
    s_d.bclk_prev = s_q.sync1.audio.bit_clock;
    s_d.lr_prev   = s_q.sync1.audio.frame_clock;
    bclk_rise     = s_q.sync1.audio.bit_clock & ~s_q.bclk_prev;
    lr_edge       = s_q.sync1.audio.frame_clock ^ s_q.lr_prev;
    if (lr_edge) begin
      s_d.bit_cnt = 6'd0;
    end else if (bclk_rise && s_q.bit_cnt != 6'(`SAMPLE_BITS)) begin
      word        = {s_q.shift[22:0], s_q.sync1.audio.serial_data};
      s_d.shift   = word;
      s_d.bit_cnt = s_q.bit_cnt + 6'd1;
      if (s_q.bit_cnt == 6'(`SAMPLE_BITS - 1)) begin
        new_v = 1'b1;
        if (!s_q.sync1.audio.frame_clock) begin
          s_d.left   = word;
          new_w.chan = 2'd0;
        end else begin
          new_w.chan = 2'd1;
          if (s_q.mode[`BIT_MODE_2P1]) begin
            s_d.sub_pend = 1'b1;
            s_d.sub_data = 24'(($signed({s_q.left[23], s_q.left})
                               + $signed({word[23], word})) >>> 1);
          end
        end
        new_w.data = condition(word, new_w.chan, s_q, mod_limit_high);
      end
    end
    new_w.dc_block = dc_block_en[new_w.chan];
    new_w.deemph   = deemph_en[new_w.chan];

    // Staging into the buffer; the sub word follows the right word
    if (s_q.st_valid && buf_ready) begin
      s_d.st_valid = 1'b0;
    end
    if (!s_d.st_valid) begin
      if (new_v) begin
        s_d.st_valid = 1'b1;
        s_d.st       = new_w;
      end else if (s_q.sub_pend) begin
        s_d.st_valid    = 1'b1;
        s_d.sub_pend    = 1'b0;
        s_d.st.chan     = 2'd2;
        s_d.st.dc_block = dc_block_en[2];
        s_d.st.deemph   = deemph_en[2];
        s_d.st.data     = condition(s_q.sub_data, 2'd2, s_q, mod_limit_high);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q           <= '0;
      s_q.mode      <= `RST_REG8;
      s_q.vol       <= `RST_REG8;
      s_q.shut      <= `RST_REG8;
      s_q.retry     <= `RST_REG8;
      s_q.pol       <= `RST_REG32;
      s_q.mux       <= `RST_REG32;
      s_q.hiz       <= 4'hf;
      s_q.clk_state <= CLK_MUTE;
      s_q.muted     <= 1'b1;
      s_q.pll_red   <= 1'b1;
      s_q.use_osc   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  clock_checker #(
    .FRAME_TIMEOUT (FRAME_TIMEOUT)
  ) u_clock_checker (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .mclk_lvl  (s_q.sync1.audio.master_clock),
    .bclk_lvl  (s_q.sync1.audio.bit_clock),
    .lrclk_lvl (s_q.sync1.audio.frame_clock),
    .clk_bad   (chk_bad),
    .mclk_bad  (chk_mbad),
    .stable    (chk_stable),
    .ratio     (chk_ratio)
  );

  // Samples are many cycles apart, so two entries ride out receiver stalls
  pcm_buffer u_pcm_buffer (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (s_q.st_valid),
    .in_data   (s_q.st),
    .in_ready  (buf_ready),
    .out_valid (pcm_valid),
    .out_data  (pcm_word),
    .out_ready (pcm_ready)
  );

  // Open-drain style: the pin is only ever pulled low
  assign addr_fault_pin_o     = 1'b0;
  assign addr_fault_pin_oe    = s_q.fault_low;
  assign bus_addr             = s_q.strap ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW;
  assign reg_rdata            = s_q.rdata;
  assign stage_hiz            = s_q.hiz;
  assign operational          = s_q.por_ok;
  assign core_clk_from_osc    = s_q.use_osc;
  assign pll_reduced          = s_q.pll_red;
  assign bclk_ratio           = s_q.ratio;
  assign audio_muted          = s_q.muted;
  assign midz_ramp_en         = s_q.mode[`BIT_MIDZ_RAMP];
  assign mode_2p1             = s_q.mode[`BIT_MODE_2P1];
  assign parallel_bridge_mode = (s_q.mux == `MUX_PARALLEL);
  assign pwm_shutdown         = s_q.shut;
  assign output_mux           = s_q.mux;
endmodule

// *** logic/amp_supervisor_map.svh ***
// Offsets, field positions, reset values and timing counts.
// Assumes a 100 MHz ref_clk; included by the supervisor, its clock checker and the bench.
`ifndef AMP_SUPERVISOR_MAP_SVH
`define AMP_SUPERVISOR_MAP_SVH
`define OFS_ERROR_STATUS    8'h02
`define OFS_SYSTEM_MODE     8'h05
`define OFS_VOLUME_UNMUTE   8'h0e
`define OFS_PWM_SHUTDOWN    8'h19
`define OFS_RETRY_DELAY     8'h1c
`define OFS_POLARITY        8'h20
`define OFS_OUTPUT_MUX      8'h25
`define BIT_MIDZ_RAMP       7
`define BIT_MODE_2P1        2
`define BIT_SOFT_UNMUTE     0
`define POL_LSB             24
`define ERR_OC              0
`define ERR_OT              1
`define ERR_UV              2
`define ERR_CLK             3
`define RST_REG8            8'h00
`define RST_REG32           32'h0000_0000
`define MUX_PARALLEL        32'h0110_3245
`define ADDR_STRAP_HIGH     7'h1b
`define ADDR_STRAP_LOW      7'h1a
`define MOD_MAX_938         24'h781061
`define MOD_MAX_992         24'h7ef9da
`define CLK_PERIOD_NS       10
`define OC_PERSIST_NS       200
`define OC_PERSIST_CYC      ((`OC_PERSIST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RETRY_UNIT_US       10
`define RETRY_UNIT_CYC      ((`RETRY_UNIT_US * 1000) / `CLK_PERIOD_NS)
`define MCLK_TIMEOUT_NS     1000
`define MCLK_TIMEOUT_CYC    (`MCLK_TIMEOUT_NS / `CLK_PERIOD_NS)
`define FRAME_TIMEOUT_US    150
`define FRAME_TIMEOUT_CYC   ((`FRAME_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define RAMP_STEP_US        100
`define RAMP_STEP_CYC       ((`RAMP_STEP_US * 1000) / `CLK_PERIOD_NS)
`define GOOD_FRAMES         4
`define SAMPLE_BITS         24
`endif

// *** logic/amp_supervisor_pkg.sv ***
// Types shared by the supervisor, its clock checker and its buffer.
// Assumes the map header sits beside it.
package amp_supervisor_pkg;
  typedef enum logic [0:0] {OC_RUN = 1'b0, OC_HOLD = 1'b1} oc_state_e;
  typedef enum logic [1:0] {
    CLK_OK   = 2'b00,
    CLK_MUTE = 2'b01,
    CLK_RAMP = 2'b11
  } clk_state_e;
  typedef struct packed {
    logic [1:0]  chan;
    logic        dc_block;
    logic        deemph;
    logic [23:0] data;
  } pcm_word_s;
  typedef struct packed {
    logic master_clock;
    logic bit_clock;
    logic frame_clock;
    logic serial_data;
  } audio_pins_s;
  typedef struct packed {
    logic [3:0] oc_detect;
    logic       overtemp_trip;
    logic       overtemp_release;
    logic       analog_uv;
    logic [1:0] stage_uv;
    logic       analog_por_ok;
    logic       stage_por_ok;
  } fault_sense_s;
  typedef struct packed {
    audio_pins_s  audio;
    fault_sense_s sense;
    logic         addr_pin;
  } pins_s;
endpackage

// *** logic/clock_checker.sv ***
// Checks master, bit and frame clocks against the oscillator clock.
// Assumes its inputs are already synchronised to ref_clk.
`timescale 1ns/1ns
`include "amp_supervisor_map.svh"
module clock_checker
  import amp_supervisor_pkg::*;
#(
  parameter int unsigned FRAME_TIMEOUT = `FRAME_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Synchronised clock levels
  input  wire logic       mclk_lvl,
  input  wire logic       bclk_lvl,
  input  wire logic       lrclk_lvl,
  // Results
  output logic            clk_bad,
  output logic            mclk_bad,
  output logic            stable,
  output logic [1:0]      ratio
);
  typedef struct packed {
    logic        mclk_prev;
    logic        bclk_prev;
    logic        lr_prev;
    logic [7:0]  mclk_cnt;
    logic [7:0]  bclk_cnt;
    logic [15:0] frame_cnt;
    logic [2:0]  good_cnt;
    logic        bad;
    logic        mbad;
    logic [1:0]  ratio;
  } chk_s;
  chk_s s_q, s_d;

  always_comb begin
    s_d           = s_q;
    s_d.mclk_prev = mclk_lvl;
    s_d.bclk_prev = bclk_lvl;
    s_d.lr_prev   = lrclk_lvl;
    // Missing master clock hands the core clock to the oscillator
    if (mclk_lvl & ~s_q.mclk_prev) begin
      s_d.mclk_cnt = 8'h00;
      s_d.mbad     = 1'b0;
    end else if (s_q.mclk_cnt == 8'(`MCLK_TIMEOUT_CYC - 1)) begin
      s_d.mbad = 1'b1;
    end else begin
      s_d.mclk_cnt = s_q.mclk_cnt + 8'h01;
    end
    if (bclk_lvl & ~s_q.bclk_prev && s_q.bclk_cnt != 8'hff) begin
      s_d.bclk_cnt = s_q.bclk_cnt + 8'h01;
    end
    if (lrclk_lvl & ~s_q.lr_prev) begin
      s_d.bclk_cnt  = 8'h00;
      s_d.frame_cnt = 16'h0000;
      unique case (s_q.bclk_cnt)
        8'd32: s_d.ratio = 2'd1;
        8'd48: s_d.ratio = 2'd2;
        8'd64: s_d.ratio = 2'd3;
        default: s_d.ratio = 2'd0;
      endcase
      s_d.bad = (s_d.ratio == 2'd0);
      if (s_d.bad) begin
        s_d.good_cnt = 3'd0;
      end else if (s_q.good_cnt != 3'(`GOOD_FRAMES)) begin
        s_d.good_cnt = s_q.good_cnt + 3'd1;
      end
    end else if (s_q.frame_cnt == 16'(FRAME_TIMEOUT - 1)) begin
      s_d.bad      = 1'b1;
      s_d.good_cnt = 3'd0;
    end else begin
      s_d.frame_cnt = s_q.frame_cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_bad  = s_q.bad;
  assign mclk_bad = s_q.mbad;
  assign stable   = (s_q.good_cnt == 3'(`GOOD_FRAMES)) & ~s_q.bad;
  assign ratio    = s_q.ratio;
endmodule

// *** logic/pcm_buffer.sv ***
// Two-entry buffer for PCM words, valid/ready on both sides.
// Assumes one clock; the head entry is the registered output.
`timescale 1ns/1ns
module pcm_buffer
  import amp_supervisor_pkg::*;
(
  // Clock and reset
  input  wire logic      ref_clk,
  input  wire logic      sys_rst,
  // Fill side
  input  wire logic      in_valid,
  input  wire pcm_word_s in_data,
  output logic           in_ready,
  // Drain side
  output logic           out_valid,
  output pcm_word_s      out_data,
  input  wire logic      out_ready
);
  typedef struct packed {
    logic      head_v;
    pcm_word_s head;
    logic      tail_v;
    pcm_word_s tail;
  } buf_s;
  buf_s s_q, s_d;

  always_comb begin
    logic pop;
    logic push;
    pop  = s_q.head_v & out_ready;
    push = in_valid & ~s_q.tail_v;
    s_d  = s_q;
    if (pop) begin
      s_d.head_v = s_q.tail_v;
      s_d.head   = s_q.tail;
      s_d.tail_v = 1'b0;
    end
    if (push) begin
      if (!s_d.head_v) begin
        s_d.head_v = 1'b1;
        s_d.head   = in_data;
      end else begin
        s_d.tail_v = 1'b1;
        s_d.tail   = in_data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Ready drops only when both entries hold words
  assign in_ready  = ~s_q.tail_v;
  assign out_valid = s_q.head_v;
  assign out_data  = s_q.head;
endmodule

// *** tb/amp_supervisor_sva.sv ***
// Checker on the supervisor ports.
// Assumes binding onto amp_supervisor.
`timescale 1ns/1ns
module amp_supervisor_sva
  import amp_supervisor_pkg::*;
(
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         sys_rst,
  // Block inputs
  input wire fault_sense_s sense_in,
  input wire logic [7:0]   reg_addr,
  input wire logic         reg_wr_en,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_rd_en,
  input wire logic         pcm_ready,
  // Block outputs
  input wire logic [31:0]  reg_rdata,
  input wire logic [3:0]   stage_hiz,
  input wire logic         addr_fault_pin_oe,
  input wire logic         midz_ramp_en,
  input wire logic         mode_2p1,
  input wire logic         pcm_valid,
  input wire pcm_word_s    pcm_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Cycles of overcurrent left unanswered
  logic [7:0] oc_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) oc_q <= 8'h00;
    else if (sense_in.oc_detect == 4'h0 || stage_hiz != 4'h0) oc_q <= 8'h00;
    else if (oc_q != 8'hff) oc_q <= oc_q + 8'h01;
  end
  hiz_gang_a: assert property (stage_hiz == 4'h0 || stage_hiz == 4'hf)
    else $error("half-bridges split");
  oc_trip_a: assert property (oc_q < 8'd26)
    else $error("overcurrent not tripped");
  uv_trip_a: assert property (sense_in.analog_uv || sense_in.stage_uv != 2'b00
    |-> ##[1:5] stage_hiz == 4'hf) else $error("undervoltage not tripped");
  ot_trip_a: assert property (sense_in.overtemp_trip |-> ##[1:5] stage_hiz == 4'hf)
    else $error("overtemp not tripped");
  pin_hold_a: assert property (addr_fault_pin_oe && !(reg_wr_en && reg_addr == 8'h02)
    |=> addr_fault_pin_oe) else $error("fault pin let go");
  mode_bits_a: assert property (reg_wr_en && reg_addr == 8'h05 |=>
    midz_ramp_en == $past(reg_wdata[7]) && mode_2p1 == $past(reg_wdata[2]))
    else $error("mode bits wrong");
  pcm_hold_a: assert property (pcm_valid && !pcm_ready |=> pcm_valid && $stable(pcm_word))
    else $error("word not held");
  bad_read_a: assert property (reg_rd_en && reg_addr == 8'h40 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind amp_supervisor amp_supervisor_sva sva (.*);

// *** tb/amp_supervisor_tb.sv ***
// Bench: registers, protection, clock check, stream.
// Assumes the source model and checker are compiled too.
`timescale 1ns/1ns
`include "amp_supervisor_map.svh"
module amp_supervisor_tb
  import amp_supervisor_pkg::*;
;
  logic         ref_clk, sys_rst, addr_fault_pin_i, addr_fault_pin_o, addr_fault_pin_oe;
  logic         reg_wr_en, reg_rd_en, mod_limit_high, operational, core_clk_from_osc;
  logic         pll_reduced, audio_muted, midz_ramp_en, mode_2p1, parallel_bridge_mode;
  logic         pcm_valid, pcm_ready, run, mclk_on, strap;
  logic [1:0]   bclk_ratio;
  logic [2:0]   dc_block_en, deemph_en;
  logic [3:0]   stage_hiz;
  logic [6:0]   bus_addr, ratio;
  logic [7:0]   reg_addr, pwm_shutdown;
  logic [7:0]   offs[6] = '{8'h05, 8'h0e, 8'h19, 8'h1c, 8'h20, 8'h25};
  logic [23:0]  lw, rw;
  logic [31:0]  reg_wdata, reg_rdata, output_mux, d;
  audio_pins_s  audio_in;
  fault_sense_s sense_in;
  pcm_word_s    pcm_word;
  pcm_word_s    notes[$];
  int           seed, frames, bad_count, samples_checked, cyc;
  amp_supervisor #(.FRAME_TIMEOUT(2000), .RAMP_STEP(20)) DUT (.*);
  audio_source src (.pins(audio_in), .*);
  // Pin pulled low only while the block drives it
  assign addr_fault_pin_i = addr_fault_pin_oe ? addr_fault_pin_o : strap;
  ////////////////////////////////////////////////////////////
  function automatic logic [23:0] clip(input logic [23:0] x);
    logic [23:0] m = mod_limit_high ? `MOD_MAX_992 : `MOD_MAX_938;
    return (!x[23] && x > m) ? m : (x[23] && x < 24'(-m)) ? 24'(-m) : x;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    tick(1);
    {reg_addr, reg_wdata, reg_wr_en} = {a, v, 1'b1};
    tick(1);
    reg_wr_en = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    tick(1);
    {reg_addr, reg_rd_en} = {a, 1'b1};
    tick(1);
    reg_rd_en = 1'b0;
    tick(1);
    check("reg_rdata", reg_rdata, e);
  endtask
  task automatic await_mute(input logic v);
    for (int i = 0; i < 12000 && audio_muted !== v; i++) tick(1);
    check("audio_muted", audio_muted, v);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
    if (pcm_valid === 1'b1 && pcm_ready === 1'b1 && notes.size() > 0)
      check("pcm_word", 32'(pcm_word), 32'(notes.pop_front()));
  end
  // Receiver stalls about a quarter of the cycles
  always @(negedge ref_clk) if (!sys_rst) pcm_ready = ($random(seed) & 3) != 0;
  initial begin
    seed = 32'hc8ff0010;
    {sys_rst, reg_wr_en, reg_rd_en, run, mclk_on, pcm_ready} = 6'b100001;
    {reg_addr, reg_wdata, sense_in, lw, rw, ratio} = {59'h0, 7'd48};
    {strap, dc_block_en, deemph_en, mod_limit_high} = 8'($random(seed));
    tick(6);
    sys_rst = 1'b0;
    sense_in.stage_por_ok = 1'b1;
    tick(10);
    check("stage_hiz", stage_hiz, 4'hf);
    sense_in.analog_por_ok = 1'b1;
    tick(10);
    check("operational", {operational, stage_hiz}, 5'h10);
    check("bus_addr", bus_addr, strap ? `ADDR_STRAP_HIGH : `ADDR_STRAP_LOW);
    foreach (offs[i]) begin
      d = $random(seed);
      rdc(offs[i], 32'h0);
      wr(offs[i], d);
      rdc(offs[i], i < 4 ? d & 32'hff : d);
    end
    rdc(8'h40, 32'h0);
    wr(8'h05, 32'h84);
    check("mode", {midz_ramp_en, mode_2p1}, 2'b11);
    {d, lw} = 0;
    foreach (offs[i]) wr(offs[i], 32'h0);
    wr(8'h25, `MUX_PARALLEL);
    wr(8'h19, 32'h3a);
    tick(1);
    check("bridge", {parallel_bridge_mode, pwm_shutdown}, 9'h13a);
    {run, mclk_on} = 2'b11;
    tick(300);
    check("osc", core_clk_from_osc, 1'b0);
    await_mute(1'b0);
    check("bclk_ratio", bclk_ratio, 2'd2);
    for (int f = 0; f < 7; f++) begin
      @(frames);
      tick(30);
      lw = (f < 6) ? 24'($random(seed)) : 24'h0;
      rw = (f < 6) ? 24'($random(seed)) : 24'h0;
      if (f < 6) notes.push_back({2'd0, dc_block_en[0], deemph_en[0], clip(lw)});
      if (f < 6) notes.push_back({2'd1, dc_block_en[1], deemph_en[1], clip(rw)});
    end
    check("lost", 32'(notes.size()), 32'h0);
    ratio = 7'd40;
    await_mute(1'b1);
    check("pll", pll_reduced, 1'b1);
    wr(8'h0e, 32'h1);
    ratio = 7'd64;
    await_mute(1'b0);
    check("bclk_ratio", {pll_reduced, bclk_ratio}, 3'd3);
    {run, mclk_on} = 2'b00;
    tick(300);
    check("osc", core_clk_from_osc, 1'b1);
    await_mute(1'b1);
    wr(8'h02, 32'h0);
    sense_in.stage_uv = 2'b10;
    tick(6);
    check("uv", {stage_hiz, addr_fault_pin_i}, 5'h1e);
    sense_in.stage_uv = 2'b00;
    tick(10);
    check("uv held", {stage_hiz, addr_fault_pin_i}, 5'h00);
    rdc(8'h02, 32'hc);
    wr(8'h02, 32'h0);
    tick(2);
    check("pin", addr_fault_pin_i, strap);
    wr(8'h1c, 32'h1);
    sense_in.oc_detect = 4'h2;
    tick(10);
    sense_in.oc_detect = 4'h0;
    tick(30);
    check("oc blip", stage_hiz, 4'h0);
    sense_in.oc_detect = 4'h8;
    tick(60);
    sense_in.oc_detect = 4'h0;
    check("oc trip", stage_hiz, 4'hf);
    tick(500);
    check("oc hold", stage_hiz, 4'hf);
    tick(600);
    check("oc retry", stage_hiz, 4'h0);
    rdc(8'h02, 32'h9);
    wr(8'h02, 32'h0);
    sense_in.overtemp_trip = 1'b1;
    tick(6);
    sense_in.overtemp_trip = 1'b0;
    tick(20);
    check("ot", {stage_hiz, addr_fault_pin_i}, 5'h1e);
    sense_in.overtemp_release = 1'b1;
    tick(10);
    check("ot release", stage_hiz, 4'h0);
    report_and_stop();
  end
endmodule

// *** tb/audio_source.sv ***
// Audio source model: master, bit, frame clocks and data.
// Assumes the bench sets words while the frame count settles.
`timescale 1ns/1ns
module audio_source
  import amp_supervisor_pkg::*;
(
  // Bench control
  input  wire logic        run,
  input  wire logic        mclk_on,
  input  wire logic [6:0]  ratio,
  input  wire logic [23:0] lw,
  input  wire logic [23:0] rw,
  // Pins
  output audio_pins_s      pins,
  output int               frames
);
  logic [47:0] sh;
  initial begin
    pins = 4'b0010;
    frames = 0;
  end
  always #20 pins.master_clock = mclk_on & ~pins.master_clock;
  ////////////////////////////////////////////////////////////
  // Bit clock stands still between frames
  always begin
    wait (run);
    sh = {lw, rw};
    for (int h = 0; h < 2; h++) begin
      pins.frame_clock = h[0];
      for (int b = 0; b < ratio / 2; b++) begin
        pins.serial_data = (b < 24) ? sh[47] : ~pins.serial_data;
        sh = (b < 24) ? sh << 1 : sh;
        #62 pins.bit_clock = 1'b1;
        #63 pins.bit_clock = 1'b0;
      end
    end
    frames++;
    #400;
  end
endmodule
